/* rtl/cbo_serial_ctl.sv */
// Purpose: Serial control port and output gating of a differential clock buffer
// Assumes: scl_i, sda_i and ref_clk_i are synchronous to core_clk_i
// Notes: Target only, transmits on reads; block writes and block reads only
`include "cbo_defines.svh"

module cbo_serial_ctl
	import cbo_pkg::*;
#(
	parameter int NUM_PAIRS = 10,
	parameter int NUM_CFG = 7
)
(
	input wire logic core_clk_i,
	input wire logic arst_n_i,
	input wire logic scl_i,
	input wire logic sda_i,
	output logic sda_o,
	output logic sda_oe_n_o,
	input wire logic ref_clk_i,
	output logic [NUM_PAIRS-1:0] true_clock_out_o,
	output logic [NUM_PAIRS-1:0] complement_clock_out_o
);

	////////////////////////////////////////////////////////////////////////////
	// Elaboration checks

	generate
		if (NUM_PAIRS != 10)
		begin : g_bad_pairs
			$error("NUM_PAIRS must be 10 to match the enable map");
		end
		if (NUM_CFG != 7)
		begin : g_bad_cfg
			$error("NUM_CFG must be 7 to match the byte layout");
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////////
	// Declarations

	localparam cbo_byte_t CFG_RST [7] = '{
		`CBO_RST_CFG0, `CBO_RST_CFG1, `CBO_RST_CFG2, `CBO_RST_CFG3,
		`CBO_RST_CFG4, `CBO_RST_CFG5, `CBO_RST_CFG6
	};

	logic scl_q;
	logic sda_q;
	cbo_bus_evt_s evt;

	cbo_state_e state_q;
	logic [3:0] bit_cnt_q;
	cbo_byte_t shift_q;
	logic [3:0] byte_idx_q;
	logic rd_mode_q;
	logic [3:0] rd_ptr_q;
	logic mack_q;
	logic sda_oe_n_q;
	logic sda_out_q;

	cbo_byte_t cfg_q [7];

	logic byte_done;
	logic addr_hit_wr;
	logic addr_hit_rd;
	logic hdr_or_cfg;
	logic rx_ack;
	logic cfg_wr;
	logic [3:0] cfg_sel;
	cbo_byte_t tx_next;
	logic [NUM_PAIRS-1:0] pair_en;

	////////////////////////////////////////////////////////////////////////////
	// Bus condition detection

	always_ff @(posedge core_clk_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
		begin
			scl_q <= 1'b1;
			sda_q <= 1'b1;
		end
		else
		begin
			scl_q <= scl_i;
			sda_q <= sda_i;
		end
	end

	always_comb
	begin
		evt.start = scl_i & scl_q & sda_q & ~sda_i;
		evt.stop = scl_i & scl_q & ~sda_q & sda_i;
		evt.rise = scl_i & ~scl_q;
		evt.fall = ~scl_i & scl_q;
	end

	////////////////////////////////////////////////////////////////////////////
	// Received byte decode

	always_comb
	begin
		byte_done = (state_q == CBO_ST_RX) && evt.fall
			&& (bit_cnt_q == 4'(`CBO_UNIT_BITS));
		addr_hit_wr = (shift_q == `CBO_WR_ADDR);
		addr_hit_rd = (shift_q == `CBO_RD_ADDR);
		hdr_or_cfg = (byte_idx_q <= `CBO_IDX_LAST_CFG);
		if (byte_idx_q == `CBO_IDX_ADDR)
			rx_ack = addr_hit_wr | addr_hit_rd;
		else
			rx_ack = hdr_or_cfg;
		cfg_wr = byte_done && !rd_mode_q
			&& (byte_idx_q >= `CBO_IDX_FIRST_CFG) && hdr_or_cfg;
		cfg_sel = byte_idx_q - `CBO_IDX_FIRST_CFG;
	end

	////////////////////////////////////////////////////////////////////////////
	// Transmit byte selection

	always_comb
	begin
		if (rd_ptr_q == 4'h0)
			tx_next = `CBO_RD_COUNT;
		else if (rd_ptr_q <= 4'(NUM_CFG))
			tx_next = cfg_q[3'(rd_ptr_q - 4'h1)];
		else
			tx_next = `CBO_RD_FILL;
	end

	////////////////////////////////////////////////////////////////////////////
	// Serial engine

	always_ff @(posedge core_clk_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
		begin
			state_q <= CBO_ST_IDLE;
			bit_cnt_q <= 4'h0;
			shift_q <= 8'h00;
			byte_idx_q <= 4'h0;
			rd_mode_q <= 1'b0;
			rd_ptr_q <= 4'h0;
			mack_q <= 1'b0;
		end
		else if (evt.start)
		begin
			state_q <= CBO_ST_RX;
			bit_cnt_q <= 4'h0;
			byte_idx_q <= 4'h0;
			rd_mode_q <= 1'b0;
			rd_ptr_q <= 4'h0;
		end
		else if (evt.stop)
		begin
			state_q <= CBO_ST_IDLE;
			bit_cnt_q <= 4'h0;
		end
		else
		begin
			unique case (state_q)
				CBO_ST_IDLE, CBO_ST_WAIT:
				begin
					bit_cnt_q <= 4'h0;
				end
				CBO_ST_RX:
				begin
					if (evt.rise && bit_cnt_q < 4'(`CBO_UNIT_BITS))
					begin
						shift_q <= {shift_q[6:0], sda_i};
						bit_cnt_q <= bit_cnt_q + 4'h1;
					end
					else if (byte_done)
					begin
						if (byte_idx_q != 4'hf)
							byte_idx_q <= byte_idx_q + 4'h1;
						if (byte_idx_q == `CBO_IDX_ADDR)
							rd_mode_q <= addr_hit_rd;
						state_q <= rx_ack ? CBO_ST_ACK : CBO_ST_WAIT;
					end
				end
				CBO_ST_ACK:
				begin
					if (evt.fall)
					begin
						bit_cnt_q <= 4'h0;
						if (rd_mode_q)
						begin
							shift_q <= tx_next;
							rd_ptr_q <= rd_ptr_q + 4'h1;
							state_q <= CBO_ST_TX;
						end
						else
						begin
							state_q <= CBO_ST_RX;
						end
					end
				end
				CBO_ST_TX:
				begin
					if (evt.fall)
					begin
						if (bit_cnt_q == 4'(`CBO_UNIT_BITS - 1))
						begin
							state_q <= CBO_ST_MACK;
						end
						else
						begin
							shift_q <= {shift_q[6:0], 1'b1};
							bit_cnt_q <= bit_cnt_q + 4'h1;
						end
					end
				end
				CBO_ST_MACK:
				begin
					if (evt.rise)
						mack_q <= ~sda_i;
					else if (evt.fall)
					begin
						bit_cnt_q <= 4'h0;
						if (mack_q)
						begin
							shift_q <= tx_next;
							if (rd_ptr_q != 4'hf)
								rd_ptr_q <= rd_ptr_q + 4'h1;
							state_q <= CBO_ST_TX;
						end
						else
						begin
							state_q <= CBO_ST_WAIT;
						end
					end
				end
				default:
				begin
					state_q <= CBO_ST_IDLE;
				end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Data line drive, open drain, enable low while pulling low

	always_ff @(posedge core_clk_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
			sda_oe_n_q <= 1'b1;
		else if (evt.start || evt.stop)
			sda_oe_n_q <= 1'b1;
		else if (state_q == CBO_ST_ACK)
			sda_oe_n_q <= 1'b0;
		else if (state_q == CBO_ST_TX)
			sda_oe_n_q <= shift_q[7];
		else
			sda_oe_n_q <= 1'b1;
	end

	always_ff @(posedge core_clk_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
			sda_out_q <= 1'b0;
		else
			sda_out_q <= 1'b0;
	end

	assign sda_o = sda_out_q;
	assign sda_oe_n_o = sda_oe_n_q;

	////////////////////////////////////////////////////////////////////////////
	// Configuration latches

	generate
		for (genvar b = 0; b < NUM_CFG; b++)
		begin : g_cfg
			always_ff @(posedge core_clk_i or negedge arst_n_i)
			begin
				if (!arst_n_i)
					cfg_q[b] <= CFG_RST[b];
				else if (cfg_wr && cfg_sel == 4'(b))
					cfg_q[b] <= shift_q;
			end
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////////
	// Output pair enable map

	always_comb
	begin
		pair_en = '1;
		pair_en[0] = cfg_q[`CBO_LO_BYTE][`CBO_EN_PAIR0];
		pair_en[2] = cfg_q[`CBO_LO_BYTE][`CBO_EN_PAIR2];
		pair_en[3] = cfg_q[`CBO_LO_BYTE][`CBO_EN_PAIR3];
		pair_en[4] = cfg_q[`CBO_LO_BYTE][`CBO_EN_PAIR4];
		pair_en[9] = cfg_q[`CBO_LO_BYTE][`CBO_EN_PAIR9];
		pair_en[5] = cfg_q[`CBO_HI_BYTE][`CBO_EN_PAIR5];
		pair_en[6] = cfg_q[`CBO_HI_BYTE][`CBO_EN_PAIR6];
		pair_en[7] = cfg_q[`CBO_HI_BYTE][`CBO_EN_PAIR7];
		pair_en[8] = cfg_q[`CBO_HI_BYTE][`CBO_EN_PAIR8];
	end

	////////////////////////////////////////////////////////////////////////////
	// Output pairs

	// One gate per pair keeps an enable change from touching any other pair
	generate
		for (genvar p = 0; p < NUM_PAIRS; p++)
		begin : g_pair
			cbo_pair_gate u_gate
			(
				.core_clk_i(core_clk_i),
				.arst_n_i(arst_n_i),
				.ref_clk_i(ref_clk_i),
				.enable_i(pair_en[p]),
				.true_clock_out_o(true_clock_out_o[p]),
				.complement_clock_out_o(complement_clock_out_o[p])
			);
		end
	endgenerate

endmodule : cbo_serial_ctl

/* rtl/cbo_defines.svh */
// Purpose: Constants of the clock buffer serial control port
// Assumes: 8-bit serial units, 20 MHz core clock
// Notes: Included by cbo_serial_ctl and by the bench
`ifndef CBO_DEFINES_SVH
`define CBO_DEFINES_SVH

// Serial target addresses, write and read
`define CBO_WR_ADDR 8'hd4
`define CBO_RD_ADDR 8'hd5

// Serial unit width and header layout of a write
`define CBO_UNIT_BITS 8
`define CBO_IDX_ADDR 4'h0
`define CBO_IDX_FIRST_CFG 4'h3
`define CBO_IDX_LAST_CFG 4'h9

// Byte count returned first in a read
`define CBO_RD_COUNT 8'h07

// Value returned for bytes read past the last configuration byte
`define CBO_RD_FILL 8'hff

// Power-on values of the configuration bytes
`define CBO_RST_CFG0 8'hff
`define CBO_RST_CFG1 8'hff
`define CBO_RST_CFG2 8'hff
`define CBO_RST_CFG3 8'hff
`define CBO_RST_CFG4 8'hff
`define CBO_RST_CFG5 8'hff
`define CBO_RST_CFG6 8'h1f

// Field positions of the output-pair enables
`define CBO_LO_BYTE 5
`define CBO_HI_BYTE 6
`define CBO_EN_PAIR0 7
`define CBO_EN_PAIR2 5
`define CBO_EN_PAIR3 4
`define CBO_EN_PAIR4 3
`define CBO_EN_PAIR9 2
`define CBO_EN_PAIR8 4
`define CBO_EN_PAIR7 3
`define CBO_EN_PAIR6 2
`define CBO_EN_PAIR5 1

`endif

/* rtl/cbo_pkg.sv */
// Purpose: Types of the clock buffer serial control port
// Assumes: Constants come from cbo_defines.svh
// Notes: None
package cbo_pkg;

	typedef logic [7:0] cbo_byte_t;

	// Serial port engine states
	typedef enum logic [2:0]
	{
		CBO_ST_IDLE = 3'b000,
		CBO_ST_RX = 3'b001,
		CBO_ST_ACK = 3'b010,
		CBO_ST_TX = 3'b011,
		CBO_ST_MACK = 3'b100,
		CBO_ST_WAIT = 3'b101
	} cbo_state_e;

	// Conditions seen on the two-wire bus in one core clock
	typedef struct packed
	{
		logic start;
		logic stop;
		logic rise;
		logic fall;
	} cbo_bus_evt_s;

endpackage : cbo_pkg

/* rtl/cbo_pair_gate.sv */
// Purpose: Gates one true/complement clock output pair
// Assumes: Reference clock sampled synchronously by the core clock
// Notes: Enable is taken over only while the reference is low
module cbo_pair_gate
	import cbo_pkg::*;
(
	input wire logic core_clk_i,
	input wire logic arst_n_i,
	input wire logic ref_clk_i,
	input wire logic enable_i,
	output logic true_clock_out_o,
	output logic complement_clock_out_o
);

	logic en_q;
	logic true_q;
	logic comp_q;

	// No high phase is cut short or started late by an enable change
	always_ff @(posedge core_clk_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
			en_q <= 1'b1;
		else if (!ref_clk_i)
			en_q <= enable_i;
	end

	// Disabled pair rests with true low and complement high
	always_ff @(posedge core_clk_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
		begin
			true_q <= 1'b0;
			comp_q <= 1'b1;
		end
		else
		begin
			true_q <= ref_clk_i & en_q;
			comp_q <= ~(ref_clk_i & en_q);
		end
	end

	assign true_clock_out_o = true_q;
	assign complement_clock_out_o = comp_q;

endmodule : cbo_pair_gate

/* testbench/cbo_serial_ctl_props.sv */
// Purpose: Port-level checks of the serial control port
// Assumes: One core clock domain, asynchronous active-low reset
// Notes: Bound to every instance of cbo_serial_ctl
module cbo_serial_ctl_props
	import cbo_pkg::*;
#(
	parameter int NUM_PAIRS = 10
)
(
	input wire logic core_clk_i,
	input wire logic arst_n_i,
	input wire logic scl_i,
	input wire logic sda_i,
	input wire logic sda_o,
	input wire logic sda_oe_n_o,
	input wire logic ref_clk_i,
	input wire logic [NUM_PAIRS-1:0] true_clock_out_o,
	input wire logic [NUM_PAIRS-1:0] complement_clock_out_o
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking @(posedge core_clk_i);
	endclocking
	default disable iff (!arst_n_i);
	sequence start_seq;
		scl_i && $past(scl_i) && $fell(sda_i);
	endsequence
	sequence stop_seq;
		scl_i && $past(scl_i) && $rose(sda_i);
	endsequence
	compl_inverse_a: assert property (complement_clock_out_o == ~true_clock_out_o)
		else $error("complement differs from inverted true");
	comp_follow_a: assert property ($past(arst_n_i) |->
		complement_clock_out_o[1] == !$past(ref_clk_i))
		else $error("complement of pair one wrong");
	pair1_follow_a: assert property ($past(arst_n_i) |->
		true_clock_out_o[1] == $past(ref_clk_i))
		else $error("pair one does not follow reference");
	ref_low_off_a: assert property ($past(arst_n_i) && !$past(ref_clk_i) |->
		true_clock_out_o == '0)
		else $error("output high while reference low");
	glitch_free_a: assert property ($past(arst_n_i, 2) && $past(ref_clk_i) &&
		$past(ref_clk_i, 2) |-> $stable(true_clock_out_o))
		else $error("outputs moved while reference high");
	oe_scl_low_a: assert property ($changed(sda_oe_n_o) |-> !scl_i && !$past(scl_i))
		else $error("data drive changed with clock high");
	ack_low_a: assert property (!sda_oe_n_o |-> sda_o == 1'b0 && sda_i == 1'b0)
		else $error("driven data wire not low");
	addr_quiet_a: assert property (start_seq |=> sda_oe_n_o [*8])
		else $error("drive right after start");
	stop_idle_a: assert property (stop_seq |=> sda_oe_n_o [*8])
		else $error("drive right after stop");
endmodule : cbo_serial_ctl_props
bind cbo_serial_ctl cbo_serial_ctl_props #(.NUM_PAIRS(NUM_PAIRS)) i_cbo_serial_ctl_props
(
	.core_clk_i(core_clk_i),
	.arst_n_i(arst_n_i),
	.scl_i(scl_i),
	.sda_i(sda_i),
	.sda_o(sda_o),
	.sda_oe_n_o(sda_oe_n_o),
	.ref_clk_i(ref_clk_i),
	.true_clock_out_o(true_clock_out_o),
	.complement_clock_out_o(complement_clock_out_o)
);

/* testbench/cbo_host_model.sv */
// Purpose: Two-wire host controller model
// Assumes: Bit time of 201 core clocks, below 100 kbit/s
// Notes: Driving one releases the wire to its pull-up
module cbo_host_model
	import cbo_pkg::*;
(
	input wire logic core_clk_i,
	input wire logic sda_i,
	output logic scl_o,
	output logic sda_o,
	output cbo_byte_t rx_o,
	output logic ack_o,
	output logic stb_o
);
	timeunit 1ns;
	timeprecision 1ns;
	initial
	begin
		scl_o = 1'b1;
		sda_o = 1'b1;
		rx_o = 8'h00;
		ack_o = 1'b1;
		stb_o = 1'b0;
	end
	task automatic ph(input logic c, input logic d);
	begin
		@(posedge core_clk_i);
		scl_o <= c;
		sda_o <= d;
		repeat (66) @(posedge core_clk_i);
	end
	endtask : ph
	task automatic start_c();
	begin
		ph(1'b1, 1'b1);
		ph(1'b1, 1'b0);
		ph(1'b0, 1'b0);
	end
	endtask : start_c
	task automatic stop_c();
	begin
		ph(1'b0, 1'b0);
		ph(1'b1, 1'b0);
		ph(1'b1, 1'b1);
	end
	endtask : stop_c
	task automatic xfer(input cbo_byte_t tx, input logic ha);
		cbo_byte_t r;
		logic a;
	begin
		for (int i = 7; i >= 0; i--)
		begin
			ph(1'b0, tx[i]);
			ph(1'b1, tx[i]);
			r[i] = sda_i;
			ph(1'b0, tx[i]);
		end
		ph(1'b0, ha);
		ph(1'b1, ha);
		a = sda_i;
		ph(1'b0, ha);
		@(posedge core_clk_i);
		rx_o <= r;
		ack_o <= a;
		stb_o <= 1'b1;
		@(posedge core_clk_i);
		stb_o <= 1'b0;
	end
	endtask : xfer
endmodule : cbo_host_model

/* testbench/cbo_serial_ctl_test.sv */
// Purpose: Self-checking bench of the serial control port
// Assumes: Host model paces the bus, reference is random
// Notes: Byte results are queued and checked by a monitor
`include "cbo_defines.svh"
module cbo_serial_ctl_test
	import cbo_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic ref_clk = 1'b0;
	logic scl, hsda, sda_w, sda_o, oe_n, ack, stb;
	cbo_byte_t rx;
	cbo_byte_t cfg [7] = '{8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'h1f};
	logic [9:0] t_out, c_out;
	logic [8:0] exp_q [$];
	int miscompares = 0;
	int num_checks = 0;
	integer seed = 32'h9b94b6b3;
	assign sda_w = oe_n ? hsda : 1'b0;
	always #25 clk = ~clk;
	always @(posedge clk) ref_clk <= 1'($random(seed));
	cbo_serial_ctl i_cbo_serial_ctl
	(
		.core_clk_i(clk),
		.arst_n_i(rst_n),
		.scl_i(scl),
		.sda_i(sda_w),
		.sda_o(sda_o),
		.sda_oe_n_o(oe_n),
		.ref_clk_i(ref_clk),
		.true_clock_out_o(t_out),
		.complement_clock_out_o(c_out)
	);
	cbo_host_model i_cbo_host_model
	(
		.core_clk_i(clk),
		.sda_i(sda_w),
		.scl_o(scl),
		.sda_o(hsda),
		.rx_o(rx),
		.ack_o(ack),
		.stb_o(stb)
	);
	task automatic cmp_byte(input logic [8:0] got, input logic [8:0] exp);
	begin
		num_checks++;
		if (got !== exp)
		begin
			miscompares++;
			$display("[FAIL] %0t got %h exp %h", $time, got, exp);
		end
	end
	endtask : cmp_byte
	task automatic cmp_pair(input logic [9:0] got_t, input logic [9:0] got_c,
		input logic [9:0] exp);
	begin
		num_checks++;
		if ({got_c, got_t} !== {~exp, exp})
		begin
			miscompares++;
			$display("[FAIL] %0t got %h exp %h", $time, {got_c, got_t}, {~exp, exp});
		end
	end
	endtask : cmp_pair
	task automatic complete_run();
	begin
		if (miscompares == 0 && num_checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	end
	endtask : complete_run
	task automatic put(input cbo_byte_t tx, input logic ha, input cbo_byte_t er, input logic ea);
	begin
		exp_q.push_back({ea, er});
		i_cbo_host_model.xfer(tx, ha);
	end
	endtask : put
	task automatic wr(input int n);
		cbo_byte_t d;
	begin
		i_cbo_host_model.start_c();
		put(`CBO_WR_ADDR, 1'b1, `CBO_WR_ADDR, 1'b0);
		for (int k = -2; k < n; k++)
		begin
			d = 8'($random(seed));
			if (k == 6)
				d[7:5] = 3'h0;
			if (k >= 0 && k < 7)
				cfg[k] = d;
			put(d, 1'b1, d, k > 6);
		end
		i_cbo_host_model.stop_c();
	end
	endtask : wr
	task automatic rd(input bit fill);
	begin
		i_cbo_host_model.start_c();
		put(`CBO_RD_ADDR, 1'b1, `CBO_RD_ADDR, 1'b0);
		put(8'hff, 1'b0, `CBO_RD_COUNT, 1'b0);
		for (int k = 0; k < 7; k++)
			put(8'hff, 1'b0, cfg[k], 1'b0);
		if (fill)
			put(8'hff, 1'b1, `CBO_RD_FILL, 1'b1);
		i_cbo_host_model.stop_c();
	end
	endtask : rd
	task automatic pairs();
		logic [9:0] m;
		logic r;
	begin
		m = {cfg[5][2], cfg[6][4:1], cfg[5][3], cfg[5][4], cfg[5][5], 1'b1, cfg[5][7]};
		@(negedge clk);
		r = ref_clk;
		repeat (8)
		begin
			@(negedge clk);
			cmp_pair(t_out, c_out, r ? m : 10'h000);
			r = ref_clk;
		end
	end
	endtask : pairs
	always @(posedge clk)
	begin
		if (stb === 1'b1)
			cmp_byte({ack, rx}, exp_q.pop_front());
	end
	initial
	begin
		repeat (100000) @(posedge clk);
		miscompares++;
		complete_run();
	end
	initial
	begin
		repeat (12) @(posedge clk);
		rst_n <= 1'b1;
		repeat (2) @(posedge clk);
		pairs();
		rd(1'b0);
		wr(8);
		pairs();
		wr(2);
		i_cbo_host_model.start_c();
		put(8'ha6, 1'b1, 8'ha6, 1'b1);
		i_cbo_host_model.stop_c();
		rd(1'b1);
		repeat (4) @(posedge clk);
		complete_run();
	end
endmodule : cbo_serial_ctl_test
